/* File: include/rx_status_consts.svh */
// Offsets, field positions, reset values and limits of the receive status bank.
// Assumes inclusion by bare name from package and design files.
`ifndef RX_STATUS_CONSTS_SVH
`define RX_STATUS_CONSTS_SVH

// Register indices and byte addresses; status and count byte addresses are four times the index
`define IDX_FRAME_STATUS   14'h017C
`define IDX_FRAME_COUNT    14'h017E
`define ADDR_FRAME_STATUS  (`IDX_FRAME_STATUS << 2)
`define ADDR_FRAME_COUNT   (`IDX_FRAME_COUNT << 2)
`define ADDR_RX_CONTROL    14'h0600
`define ADDR_RX_ADVANCE    14'h0604
`define ADDR_W             14

// Status word fields
`define ST_VALID    15
`define ST_ICMP     13
`define ST_IPHDR    12
`define ST_TCP      11
`define ST_UDP      10
`define ST_BCAST    7
`define ST_MCAST    6
`define ST_UCAST    5
`define ST_FTYPE    3
`define ST_RUNT     1
`define ST_CRC      0
`define ST_RSVD_MASK 16'h4314

// Control and advance fields
`define CTL_PASS_BAD   0
`define ADV_NEXT       0
`define PASS_BAD_RST   1'b0

// Frame classification
`define LEN_TYPE_MAX   16'h05DC
`define BCAST_ADDR     48'hFFFF_FFFF_FFFF
`define GROUP_BIT      40

// Bus encodings
`define HTRANS_NONSEQ  2'h2
`define HSIZE_WORD     3'h2
`define HRESP_OKAY     1'b0

`endif

/* File: include/rx_status_pkg.sv */
// Types shared by the receive status bank and its classifier.
// Assumes the constants header is on the include path.
`include "rx_status_consts.svh"
package rx_status_pkg;
   typedef logic [15:0] status_word_t;
   typedef logic [11:0] byte_count_t;
   typedef logic [31:0] bus_word_t;
   typedef logic [47:0] mac_addr_t;
endpackage

/* File: include/rx_class_if.sv */
// Raw frame facts in, status word and keep decision out.
// Assumes the classifier is purely combinational.
`timescale 1ns/1ns
`default_nettype none
interface rx_class_if;
   import rx_status_pkg::*;
   mac_addr_t    dst_addr;
   logic [15:0]  len_type;
   logic         runt;
   logic         crc_bad;
   logic [3:0]   csum_bad;
   logic         pass_bad;
   status_word_t status_word;
   logic         keep;
   modport cls (input dst_addr, len_type, runt, crc_bad, csum_bad, pass_bad,
                output status_word, keep);
   modport top (output dst_addr, len_type, runt, crc_bad, csum_bad, pass_bad,
                input status_word, keep);
endinterface
`default_nettype wire

/* File: rtl/rx_frame_classifier.sv */
// Builds the header status word of one finished frame and decides if it is kept.
// Assumes csum_bad is {icmp, ip header, tcp, udp}.
`timescale 1ns/1ns
`default_nettype none
`include "rx_status_consts.svh"
module rx_frame_classifier (
   rx_class_if.cls cls     // Frame facts and status
);
   import rx_status_pkg::*;

   logic bcast;
   logic mcast;

   assign bcast = (cls.dst_addr == `BCAST_ADDR);
   assign mcast = cls.dst_addr[`GROUP_BIT];

   always_comb begin
      cls.status_word = '0;
      cls.status_word[`ST_VALID] = 1'b1;
      cls.status_word[`ST_ICMP]  = cls.csum_bad[3];
      cls.status_word[`ST_IPHDR] = cls.csum_bad[2];
      cls.status_word[`ST_TCP]   = cls.csum_bad[1];
      cls.status_word[`ST_UDP]   = cls.csum_bad[0];
      cls.status_word[`ST_BCAST] = bcast;
      cls.status_word[`ST_MCAST] = mcast | bcast;
      cls.status_word[`ST_UCAST] = ~(mcast | bcast);
      // Meaningless for runts, left as computed
      cls.status_word[`ST_FTYPE] = (cls.len_type > `LEN_TYPE_MAX);
      cls.status_word[`ST_RUNT]  = cls.runt;
      cls.status_word[`ST_CRC]   = cls.crc_bad;
   end

   assign cls.keep = ~((cls.runt | cls.crc_bad) & ~cls.pass_bad);

endmodule // rx_frame_classifier
`default_nettype wire

/* File: rtl/rx_frame_header_status.sv */
// Receive frame header status bank: per-frame status queue behind AHB-Lite.
// Assumes frame facts are valid in the cycle frame_done is high.
//
// The AHB-Lite register port was chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
`include "rx_status_consts.svh"

module rx_frame_header_status #(
   parameter int DEPTH = 4                        // Queued frames
) (
   input  wire logic                      clock,        // System clock
   input  wire logic                      rst_n,        // Sync reset, low
   input  wire logic                      hsel,         // Slave select
   input  wire logic [31:0]               haddr,        // Byte address
   input  wire logic [1:0]                htrans,       // Transfer type
   input  wire logic                      hwrite,       // Write
   input  wire logic [2:0]                hsize,        // Transfer size
   input  wire logic                      hready,       // Bus ready
   input  wire rx_status_pkg::bus_word_t  hwdata,       // Write data
   output var  rx_status_pkg::bus_word_t  hrdata,       // Read data
   output logic                           hreadyout,    // Slave ready
   output logic                           hresp,        // Always OKAY
   input  wire logic                      frame_done,   // Frame ended, pulse
   input  wire rx_status_pkg::byte_count_t frame_bytes, // Frame size
   input  wire rx_status_pkg::mac_addr_t  dst_addr,     // Destination
   input  wire logic [15:0]               len_type,     // Length/type
   input  wire logic                      runt_in,      // Collision or early end
   input  wire logic                      crc_bad_in,   // CRC failed
   input  wire logic [3:0]                csum_bad_in,  // ICMP, IP, TCP, UDP
   output logic                           frame_accept  // Queue has room
);
   import rx_status_pkg::*;

   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   // Pointers wrap freely, so only powers of two work
   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_depth_check
      $error("DEPTH must be a power of two, at least 2");
   end

   rx_class_if cls_if ();

   rx_frame_classifier u_classifier (
      .cls (cls_if.cls)
   );

   logic pass_bad_ff;

   assign cls_if.dst_addr = dst_addr;
   assign cls_if.len_type = len_type;
   assign cls_if.runt     = runt_in;
   assign cls_if.crc_bad  = crc_bad_in;
   assign cls_if.csum_bad = csum_bad_in;
   assign cls_if.pass_bad = pass_bad_ff;

   // Frame status queue
   status_word_t      status_mem [DEPTH];
   byte_count_t       count_mem  [DEPTH];
   logic [AW-1:0]     wr_ptr_ff;
   logic [AW-1:0]     rd_ptr_ff;
   logic [AW:0]       level_ff;
   logic              full;
   logic              empty;
   logic              push;
   logic              pop;
   status_word_t      head_word;
   byte_count_t       head_cnt;

   assign full         = (level_ff == (AW+1)'(DEPTH));
   assign empty        = (level_ff == '0);
   assign frame_accept = ~full;
   assign push         = frame_done & cls_if.keep & ~full;

   // Nothing pending shows as an all-zero word
   assign head_word = empty ? '0 : status_mem[rd_ptr_ff];
   assign head_cnt  = empty ? '0 : count_mem[rd_ptr_ff];

   always_ff @(posedge clock) begin
      if (push) begin
         status_mem[wr_ptr_ff] <= cls_if.status_word;
         count_mem[wr_ptr_ff]  <= frame_bytes;
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n)
         wr_ptr_ff <= '0;
      else if (push)
         wr_ptr_ff <= wr_ptr_ff + AW'(1);
   end

   // Head only moves on host advance
   always_ff @(posedge clock) begin
      if (!rst_n)
         rd_ptr_ff <= '0;
      else if (pop)
         rd_ptr_ff <= rd_ptr_ff + AW'(1);
   end

   always_ff @(posedge clock) begin
      if (!rst_n)
         level_ff <= '0;
      else if (push && !pop)
         level_ff <= level_ff + (AW+1)'(1);
      else if (pop && !push)
         level_ff <= level_ff - (AW+1)'(1);
   end

   // AHB-Lite slave
   logic                accept;
   logic                wr_pend_ff;
   logic                rd_wait_ff;
   logic [`ADDR_W-1:0]  addr_ff;
   logic                adv_wr;
   bus_word_t           nxt_hrdata;
   bus_word_t           hrdata_ff;

   assign accept = hsel & hready & (htrans == `HTRANS_NONSEQ)
                   & (hsize == `HSIZE_WORD);

   always_ff @(posedge clock) begin
      if (!rst_n)
         addr_ff <= '0;
      else if (accept)
         addr_ff <= haddr[`ADDR_W-1:0];
   end

   always_ff @(posedge clock) begin
      if (!rst_n)
         wr_pend_ff <= 1'b0;
      else if (hready)
         wr_pend_ff <= accept & hwrite;
   end

   // One wait state lets a prior advance settle
   always_ff @(posedge clock) begin
      if (!rst_n)
         rd_wait_ff <= 1'b0;
      else
         rd_wait_ff <= accept & ~hwrite;
   end

   assign hreadyout = ~rd_wait_ff;
   assign hresp     = `HRESP_OKAY;

   // Writes reach only control and advance
   always_ff @(posedge clock) begin
      if (!rst_n)
         pass_bad_ff <= `PASS_BAD_RST;
      else if (wr_pend_ff && addr_ff == `ADDR_RX_CONTROL)
         pass_bad_ff <= hwdata[`CTL_PASS_BAD];
   end

   assign adv_wr = wr_pend_ff & (addr_ff == `ADDR_RX_ADVANCE)
                   & hwdata[`ADV_NEXT];
   assign pop    = adv_wr & ~empty;

   always_comb begin
      nxt_hrdata = '0;
      unique case (addr_ff)
         `ADDR_FRAME_STATUS: nxt_hrdata[15:0] = head_word;
         `ADDR_FRAME_COUNT:  nxt_hrdata[11:0] = head_cnt;
         `ADDR_RX_CONTROL:   nxt_hrdata[`CTL_PASS_BAD] = pass_bad_ff;
         `ADDR_RX_ADVANCE:   nxt_hrdata[AW:0] = level_ff;
         default:            nxt_hrdata = '0;
      endcase
   end

   always_ff @(posedge clock) begin
      if (!rst_n)
         hrdata_ff <= '0;
      else if (rd_wait_ff)
         hrdata_ff <= nxt_hrdata;
   end

   assign hrdata = hrdata_ff;

   // Checks
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   AST_VALID_LOW_EMPTY: assert property (
      empty |-> !head_word[`ST_VALID])
      else $error("valid flag high with empty queue");

   AST_VALID_AFTER_PUSH: assert property (
      push |=> head_word[`ST_VALID])
      else $error("valid flag low after frame queued");

   AST_ICMP_FLAG: assert property (
      push && empty |=> head_word[`ST_ICMP] == $past(csum_bad_in[3]))
      else $error("icmp checksum flag mismatch");

   AST_IPHDR_FLAG: assert property (
      push && empty |=> head_word[`ST_IPHDR] == $past(csum_bad_in[2]))
      else $error("ip header checksum flag mismatch");

   AST_TCP_UDP_FLAG: assert property (
      push && empty |=> head_word[`ST_TCP] == $past(csum_bad_in[1])
                        && head_word[`ST_UDP] == $past(csum_bad_in[0]))
      else $error("tcp or udp checksum flag mismatch");

   AST_BCAST_IS_MCAST: assert property (
      head_word[`ST_BCAST] |-> head_word[`ST_MCAST])
      else $error("broadcast without multicast flag");

   AST_UCAST_EXCL: assert property (
      head_word[`ST_VALID] |-> head_word[`ST_UCAST] != head_word[`ST_MCAST])
      else $error("unicast and multicast flags agree");

   AST_FRAME_TYPE: assert property (
      push && empty && !runt_in
      |=> head_word[`ST_FTYPE] == ($past(len_type) > `LEN_TYPE_MAX))
      else $error("frame type flag mismatch");

   AST_BAD_DROPPED: assert property (
      frame_done && (runt_in || crc_bad_in) && !pass_bad_ff && !pop
      |=> level_ff == $past(level_ff))
      else $error("bad frame queued without pass-bad");

   AST_BYTE_COUNT: assert property (
      push && empty |=> head_cnt == $past(frame_bytes))
      else $error("byte count mismatch");

   AST_HEAD_STABLE: assert property (
      !empty && !pop |=> $stable(head_word) && $stable(head_cnt))
      else $error("head changed without advance");

   AST_READ_ONE_WAIT: assert property (
      accept && !hwrite |=> !hreadyout ##1 hreadyout)
      else $error("read answer not after one wait state");

   AST_WRITE_NO_WAIT: assert property (
      accept && hwrite |=> hreadyout)
      else $error("write data phase stretched");

   AST_HRDATA_HOLD: assert property (
      !rd_wait_ff |=> $stable(hrdata))
      else $error("read data changed outside a read");

   AST_READ_STATUS: assert property (
      rd_wait_ff && addr_ff == `ADDR_FRAME_STATUS
      |=> hrdata == bus_word_t'($past(head_word)))
      else $error("status read data mismatch");

   AST_READ_COUNT: assert property (
      rd_wait_ff && addr_ff == `ADDR_FRAME_COUNT
      |=> hrdata == bus_word_t'($past(head_cnt)))
      else $error("count read data mismatch");

   AST_CONTROL_WRITE: assert property (
      wr_pend_ff && addr_ff == `ADDR_RX_CONTROL
      |=> pass_bad_ff == $past(hwdata[`CTL_PASS_BAD]))
      else $error("pass-bad control not written");

   // Queue bookkeeping
   AST_LEVEL_BOUND: assert property (
      level_ff <= (AW+1)'(DEPTH))
      else $error("queue level above depth");

   AST_PUSH_LEVEL: assert property (
      push && !pop |=> level_ff == $past(level_ff) + (AW+1)'(1))
      else $error("level not raised by queued frame");

   AST_POP_LEVEL: assert property (
      pop && !push |=> level_ff == $past(level_ff) - (AW+1)'(1))
      else $error("level not lowered by advance");

   AST_FULL_DROP: assert property (
      frame_done && full && !pop |=> level_ff == $past(level_ff))
      else $error("frame queued while full");

   AST_GOOD_KEPT: assert property (
      frame_done && !full && !runt_in && !crc_bad_in |-> push)
      else $error("good frame not queued");

   AST_BAD_PASSED: assert property (
      frame_done && !full && pass_bad_ff |-> push)
      else $error("frame dropped with pass-bad set");

   AST_POP_ONLY_ADV: assert property (
      pop |-> wr_pend_ff && addr_ff == `ADDR_RX_ADVANCE)
      else $error("head moved without advance write");

   AST_PTR_GAP: assert property (
      !empty && !full |-> wr_ptr_ff != rd_ptr_ff)
      else $error("write pointer on queued head");

   // Head contents
   AST_VALID_NONEMPTY: assert property (
      !empty |-> head_word[`ST_VALID])
      else $error("valid flag low with frame queued");

   AST_COUNT_EMPTY: assert property (
      empty |-> head_cnt == '0)
      else $error("byte count nonzero with empty queue");

   AST_RESERVED_ZERO: assert property (
      (head_word & `ST_RSVD_MASK) == '0)
      else $error("reserved status bit set");

   AST_CRC_RUNT_FLAG: assert property (
      push && empty |=> head_word[`ST_CRC] == $past(crc_bad_in)
                        && head_word[`ST_RUNT] == $past(runt_in))
      else $error("crc or runt flag mismatch");

   AST_BCAST_FLAG: assert property (
      push && empty
      |=> head_word[`ST_BCAST] == ($past(dst_addr) == `BCAST_ADDR))
      else $error("broadcast flag mismatch");

   AST_MCAST_FLAG: assert property (
      push && empty
      |=> head_word[`ST_MCAST] == ($past(dst_addr[`GROUP_BIT])
                                   || $past(dst_addr) == `BCAST_ADDR))
      else $error("multicast flag mismatch");

   COV_PUSH_POP: cover property (push ##[1:20] pop);
   COV_RUNT_PASSED: cover property (push && pass_bad_ff && runt_in);
   COV_FULL: cover property (full && frame_done);
   COV_BAD_PASSED: cover property (push && pass_bad_ff && crc_bad_in);
   COV_STATUS_READ: cover property (
      accept && !hwrite && haddr[`ADDR_W-1:0] == `ADDR_FRAME_STATUS);

endmodule // rx_frame_header_status
`default_nettype wire

/* File: verification/ahb_host_model.sv */
// Host side model: AHB-Lite master making single whole-word transfers.
// Assumes one slave whose hreadyout comes back as hready.
`timescale 1ns/1ns
`default_nettype none
`include "rx_status_consts.svh"
module ahb_host_model (
   input  wire logic                     clock,   // System clock
   input  wire logic                     hready,  // Bus ready
   input  wire rx_status_pkg::bus_word_t hrdata,  // Read data
   output logic                          hsel,    // Slave select
   output logic [31:0]                   haddr,   // Byte address
   output logic [1:0]                    htrans,  // Transfer type
   output logic                          hwrite,  // Write
   output logic [2:0]                    hsize,   // Size
   output rx_status_pkg::bus_word_t      hwdata,  // Write data
   output rx_status_pkg::bus_word_t      rdata,   // Last read word
   output logic                          rdone    // Read finished, pulse
);
   import rx_status_pkg::*;
   initial begin
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = `HSIZE_WORD;
      hwdata = 32'h0;
      rdata = 32'h0;
      rdone = 1'b0;
   end
   // Whole words only, so no byte order applies; one transfer per call
   task automatic xfer(input logic w, input logic [31:0] a, input bus_word_t d);
      @(posedge clock);
      hsel   <= 1'b1;
      haddr  <= a;
      htrans <= `HTRANS_NONSEQ;
      hwrite <= w;
      do @(posedge clock); while (hready !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clock); while (hready !== 1'b1);
      rdata  <= hrdata;
      rdone  <= !w;
      @(posedge clock);
      rdone  <= 1'b0;
   endtask
endmodule // ahb_host_model
`default_nettype wire

/* File: verification/rx_frame_header_status_test.sv */
// Self-checking bench for the receive status bank.
// Assumes the host model drives the bus; bench drives frame facts.
`timescale 1ns/1ns
`default_nettype none
`include "rx_status_consts.svh"
module rx_frame_header_status_test;
   import rx_status_pkg::*;
   localparam logic [31:0] ST = 32'(`ADDR_FRAME_STATUS);
   localparam logic [31:0] CT = 32'(`ADDR_FRAME_COUNT);
   localparam logic [31:0] CTL = 32'(`ADDR_RX_CONTROL);
   localparam logic [31:0] ADV = 32'(`ADDR_RX_ADVANCE);
   logic        clock = 1'b0;
   logic        rst_n = 1'b0;
   logic        hsel, hwrite, hready, rdone, frame_done = 1'b0;
   logic [31:0] haddr;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   bus_word_t   hwdata, hrdata, rdata, e, m, seed;
   byte_count_t frame_bytes = 12'h0;
   mac_addr_t   dst_addr = 48'h0;
   logic [15:0] len_type = 16'h0;
   logic        runt_in = 1'b0, crc_bad_in = 1'b0;
   logic [3:0]  csum_bad_in = 4'h0;
   logic        hresp, frame_accept;
   bus_word_t   exp_q[$], msk_q[$];
   string       nm_q[$];
   int          n_mismatch = 0, cmp_count = 0, i;
   always #20 clock = ~clock;
   rx_frame_header_status #(.DEPTH(4)) uut (.clock(clock), .rst_n(rst_n), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready),
      .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hready), .hresp(hresp),
      .frame_done(frame_done), .frame_bytes(frame_bytes), .dst_addr(dst_addr),
      .len_type(len_type), .runt_in(runt_in), .crc_bad_in(crc_bad_in),
      .csum_bad_in(csum_bad_in), .frame_accept(frame_accept));
   ahb_host_model host (.clock(clock), .hready(hready), .hrdata(hrdata), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .rdata(rdata), .rdone(rdone));
   function automatic bus_word_t exp_st(mac_addr_t d, logic [15:0] lt, logic r, logic c,
                                        logic [3:0] cs);
      exp_st = 32'h0;
      exp_st[15] = 1'b1;
      exp_st[13:10] = cs;
      exp_st[7] = (d === `BCAST_ADDR);
      exp_st[6] = d[`GROUP_BIT];
      exp_st[5] = !d[`GROUP_BIT];
      exp_st[3] = (lt > 16'd1500);
      exp_st[1] = r;
      exp_st[0] = c;
   endfunction
   task automatic rd(input logic [31:0] a, input bus_word_t ev, input bus_word_t mk,
                     input string nm);
      exp_q.push_back(ev);
      msk_q.push_back(mk);
      nm_q.push_back(nm);
      host.xfer(1'b0, a, 32'h0);
   endtask
   task automatic wr(input logic [31:0] a, input bus_word_t d);
      host.xfer(1'b1, a, d);
   endtask
   // Raises frame_done with facts; caller lowers it after the last frame
   task automatic fr(input mac_addr_t d, input logic [15:0] lt, input logic r,
                     input logic c, input logic [3:0] cs, input byte_count_t b);
      @(posedge clock);
      frame_done  <= 1'b1;
      dst_addr    <= d;
      len_type    <= lt;
      runt_in     <= r;
      crc_bad_in  <= c;
      csum_bad_in <= cs;
      frame_bytes <= b;
   endtask
   task automatic fr_end;
      @(posedge clock);
      frame_done <= 1'b0;
   endtask
   task automatic chk(input string nm, input bus_word_t ev, input bus_word_t mk,
                      input bus_word_t got);
      cmp_count++;
      if ((got & mk) !== (ev & mk)) begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", nm, ev, got);
      end
   endtask
   always @(posedge clock) begin
      if (rdone === 1'b1) begin
         chk("hresp", 32'(`HRESP_OKAY), '1, 32'(hresp));
         if (exp_q.size() == 0)
            chk("unexpected read", 32'h0, '1, 32'h1);
         else
            chk(nm_q.pop_front(), exp_q.pop_front(), msk_q.pop_front(), rdata);
      end
   end
   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clock);
      n_mismatch++;
      give_verdict;
   end
   initial begin
      mac_addr_t d;
      seed = $urandom(79);
      repeat (20) @(posedge clock);
      rst_n <= 1'b1;
      chk("accept_empty", 32'h1, '1, 32'(frame_accept));
      rd(ST, 32'h0, '1, "status_empty");
      rd(CT, 32'h0, '1, "count_empty");
      rd(32'h0000_0100, 32'h0, '1, "unmapped");
      $display("test empty done");
      wr(CTL, 32'h1);
      for (i = 0; i < 8; i++) begin
         d = (i % 3 == 0) ? `BCAST_ADDR : 48'({$urandom, $urandom});
         if (i % 3 != 0)
            d[`GROUP_BIT] = (i % 3 == 1);
         e = exp_st(d, i[0] ? 16'h05DD : 16'h05DC, i == 4, i == 5, 4'h1 << (i % 4));
         m = (i == 4) ? 32'hFFFF_FFF7 : '1;
         fr(d, i[0] ? 16'h05DD : 16'h05DC, i == 4, i == 5, 4'h1 << (i % 4), 12'(i * 517));
         fr_end;
         rd(ST, e, m, "status");
         rd(CT, 32'(i * 517) & 32'hFFF, '1, "count");
         wr(ST, $urandom);
         rd(ST, e, m, "status_after_write");
         wr(ADV, 32'h1);
      end
      rd(ST, 32'h0, '1, "status_drained");
      $display("test flags done");
      wr(CTL, 32'h0);
      fr(48'h0200_0000_0001, 16'h0800, 1'b0, 1'b1, 4'h0, 12'h040);
      fr(48'h0200_0000_0001, 16'h0800, 1'b1, 1'b0, 4'h0, 12'h020);
      for (i = 0; i < 5; i++)
         fr(48'h0200_0000_0002, 16'h0800, 1'b0, 1'b0, 4'h0, 12'(100 + i));
      fr_end;
      chk("accept_full", 32'h0, '1, 32'(frame_accept));
      rd(ADV, 32'h4, '1, "level_full");
      for (i = 0; i < 4; i++) begin
         rd(ST, exp_st(48'h0200_0000_0002, 16'h0800, 1'b0, 1'b0, 4'h0), '1, "status_q");
         rd(CT, 32'(100 + i), '1, "count_q");
         wr(ADV, 32'h1);
      end
      rd(ST, 32'h0, '1, "status_end");
      $display("test drop and queue done");
      repeat (3) @(posedge clock);
      give_verdict;
   end
endmodule // rx_frame_header_status_test
`default_nettype wire
